/* File: hw/ufcam_addr_match.v */
`timescale 1ns/1ns
// given and broadcast address comparison, purely combinational
module ufcam_addr_match #(
  parameter W = 8                      // address width
) (
  // address inputs
  input  wire [W-1:0] rx_addr_i,       // received address byte
  input  wire [W-1:0] own_addr_i,      // own address register
  input  wire [W-1:0] mask_i,          // mask register
  // result
  output wire         given_o,         // matched given address
  output wire         bcast_o,         // matched broadcast address
  output wire         match_o          // either one
);

  wire [W-1:0] given_ok;               // per-bit given result
  wire [W-1:0] bcast_ok;               // per-bit broadcast result

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // mask zero is don't-care, mask one must equal own bit
      assign given_ok[i] = !mask_i[i] || (rx_addr_i[i] == own_addr_i[i]);
      // where own OR mask is one the received bit must be one
      assign bcast_ok[i] = !(own_addr_i[i] | mask_i[i]) || rx_addr_i[i];
    end
  endgenerate

  // after reset both registers are zero, so everything matches
  assign given_o = &given_ok;
  assign bcast_o = &bcast_ok;
  assign match_o = given_o || bcast_o;

endmodule

/* File: hw/ufcam_baud_tick.v */
`timescale 1ns/1ns
// oversampling tick divider: one-cycle pulse every divisor+1 clocks
module ufcam_baud_tick #(
  parameter W = 16                     // divisor width
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         srst_i,
  // control
  input  wire [W-1:0] divisor_i,       // clocks per tick minus one
  input  wire         run_i,           // counter held in reset when low
  // tick out
  output wire         tick_o
);

  reg [W-1:0] cnt_r;                   // down counter

  // reload on zero; holding it while idle aligns ticks to start edges
  always @(posedge clk_i) begin
    if (srst_i || !run_i) begin
      cnt_r <= {W{1'b0}};
    end else if (cnt_r == {W{1'b0}}) begin
      cnt_r <= divisor_i;
    end else begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign tick_o = run_i && (cnt_r == {W{1'b0}});

endmodule

/* File: hw/ufcam_consts.vh */
// Operation
// - framing check only modes 1-3, when enabled
// - invalid stop bit sets frame error flag
// - frame error stays until software write or reset
// - with checking, receive done at stop bit
// - address recognition follows multidrop enable bit
// - address frames accepted only on given/broadcast match
// - mode 1 multidrop: stop bit acts as ninth
// - mode 0 ignores multidrop enable entirely
// - given address: masked compare with own address
// - broadcast: own OR mask ones must match
// - own address and mask reset to zero
// - serial control at 98h, fixed bit layout
// - bit 7 is frame error or mode bit 0
// - mode bits select shift, 8-bit, 9-bit modes
`ifndef UFCAM_CONSTS_VH
`define UFCAM_CONSTS_VH

// register byte addresses
`define UFCAM_OFS_SERCTL   8'h98
`define UFCAM_OFS_PWRCTL   8'h9C
`define UFCAM_OFS_ADDR     8'hA0
`define UFCAM_OFS_MASK     8'hA4
`define UFCAM_OFS_RXDATA   8'hA8
`define UFCAM_OFS_ISTAT    8'hAC
`define UFCAM_OFS_IMASK    8'hB0
`define UFCAM_OFS_BAUD     8'hB4

// serial control bit positions
`define UFCAM_SC_FERR_MODE0 7
`define UFCAM_SC_MODE1     6
`define UFCAM_SC_MDROP     5
`define UFCAM_SC_REN       4
`define UFCAM_SC_TX9       3
`define UFCAM_SC_RX9       2
`define UFCAM_SC_TXDONE    1
`define UFCAM_SC_RXDONE    0

// power control: frame check enable bit
`define UFCAM_PC_FCE       0

// interrupt status bits
`define UFCAM_IS_RXDONE    0
`define UFCAM_IS_FERR      1
`define UFCAM_IS_DROP      2
// status bits allowed onto the interrupt line: delivery and framing error
`define UFCAM_IRQ_SRC      3'h3

// reset values
`define UFCAM_RST_SERCTL   8'h00
`define UFCAM_RST_ADDR     8'h00
`define UFCAM_RST_MASK     8'h00
`define UFCAM_RST_BAUD     16'h0004

// timing: oversampling ticks per bit and to bit centre
`define UFCAM_TICKS_BIT    4'hF
`define UFCAM_TICKS_HALF   4'h7

`endif

/* File: hw/ufcam_top.v */
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`include "ufcam_consts.vh"
// receive path with framing check and address recognition, APB registers
module ufcam_top #(
  parameter DIV_W = 16                 // baud divisor width
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        srst_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output wire        pready_o,
  output wire        pslverr_o,
  output wire [31:0] prdata_o,
  // serial line
  input  wire        rxd_i,            // receive data, idle high
  output wire        tx_ninth_bit_o,   // ninth bit for a transmitter
  // interrupt
  output wire        irq_o             // level, high while unmasked delivery or framing event
);

  // receiver states
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_START = 2'b01;
  localparam [1:0] ST_DATA  = 2'b10;
  localparam [1:0] ST_STOP  = 2'b11;

  // register map, one aligned word each, data in the low bits:
  //   serial control  - mode, multidrop, enable, ninth bits, flags
  //   power control   - bit 0 turns the framing check on
  //   own address     - individual address byte
  //   address mask    - zero bits are don't-care in the given match, own decides them in broadcast
  //   received byte   - read only, loaded only on acceptance
  //   event status    - read only, a read clears what it showed
  //   event mask      - one enable per status bit
  //   baud divisor    - clocks per oversample tick minus one
  // unmapped offsets answer with an error and read as zero;
  // writes to the read-only words are quietly ignored

  // serial control fields
  reg        mode_select_bit0_r;       // mode bit 0
  reg        mode_select_bit1_r;       // mode bit 1
  reg        multidrop_enable_r;       // address recognition enable
  reg        rx_enable_r;              // reception enable
  reg        tx_ninth_bit_r;           // ninth bit to send
  reg        rx_ninth_bit_r;           // ninth or stop bit received
  reg        transmit_done_flag_r;     // software-visible only here
  reg        receive_done_flag_r;      // frame delivered
  reg        frame_error_flag_r;       // sticky framing error
  reg        frame_check_enable_r;     // power control bit
  // address and data
  reg  [7:0] own_address_r;            // own address register
  reg  [7:0] address_mask_r;           // mask register
  reg  [7:0] rx_data_r;                // last accepted byte
  reg  [DIV_W-1:0] baud_div_r;         // clocks per oversample tick - 1
  // interrupt block
  reg  [2:0] istat_r;                  // sticky events
  reg  [2:0] imask_r;                  // enables
  reg  [2:0] istat_seen_r;             // bits shown by the pending read
  // apb read data
  reg  [31:0] prdata_r;                // latched in setup cycle
  // receiver
  reg  [1:0] state_r;                  // receiver state
  reg  [3:0] tick_cnt_r;               // ticks inside a bit
  reg  [3:0] bit_cnt_r;                // data bit index
  reg  [8:0] shift_r;                  // data bits, ninth at top

  // decoded mode: 0 shift reg, 1 8-bit, 2 9-bit fixed, 3 9-bit variable
  wire [1:0] mode = {mode_select_bit0_r, mode_select_bit1_r};
  wire       async_mode = (mode != 2'b00);
  wire       nine_bit   = mode[1];     // modes 2 and 3
  // mode 0 masks multidrop so it can have no effect there
  wire       mdrop_eff  = multidrop_enable_r && async_mode;
  wire       fcheck_eff = frame_check_enable_r && async_mode;
  wire [3:0] last_bit   = nine_bit ? 4'h8 : 4'h7;

  // the slave never stalls: every access completes in its first
  // access cycle, and a write lands at the edge that ends it.
  // read data is taken from the setup cycle so that the event
  // status snapshot and its clear refer to the same bits
  // apb decode
  wire       setup_ph  = psel_i && !penable_i;
  wire       access_ph = psel_i && penable_i;
  wire       wr_en     = access_ph && pwrite_i;
  wire       rd_en     = access_ph && !pwrite_i;
  reg        addr_hit;                 // address is mapped
  wire       wr_serctl = wr_en && (paddr_i == `UFCAM_OFS_SERCTL);
  wire       rd_istat  = rd_en && (paddr_i == `UFCAM_OFS_ISTAT);

  // oversample tick
  wire       tick;
  wire       rx_run = (state_r != ST_IDLE);

  ufcam_baud_tick #(
    .W         (DIV_W)
  ) u_tick (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .divisor_i (baud_div_r),
    .run_i     (rx_run),
    .tick_o    (tick)
  );

  // both matches follow the byte as it builds up; only the value
  // present at the delivery sample is ever used
  // address comparison on the low eight received bits
  wire       addr_match;

  ufcam_addr_match #(
    .W          (8)
  ) u_match (
    .rx_addr_i  (shift_r[7:0]),
    .own_addr_i (own_address_r),
    .mask_i     (address_mask_r),
    .given_o    (),
    .bcast_o    (),
    .match_o    (addr_match)
  );

  // receiver timing: sixteen oversample ticks per bit. the start
  // bit is checked at its centre (eighth tick), every later bit is
  // sampled sixteen ticks after the one before. the tick divider
  // only runs while a frame is in flight, so each frame starts its
  // tick train from its own falling edge and drift never builds up
  // across frames. limitation: one sample per bit, no majority vote,
  // so a spike at a bit centre is taken as data

  // sampling points
  wire bit_end    = tick && (tick_cnt_r == `UFCAM_TICKS_BIT);
  wire start_mid  = tick && (tick_cnt_r == `UFCAM_TICKS_HALF) && (state_r == ST_START);
  wire data_smp   = bit_end && (state_r == ST_DATA);
  wire last_smp   = data_smp && (bit_cnt_r == last_bit);
  wire stop_smp   = bit_end && (state_r == ST_STOP);
  // delivery waits for the stop bit when it carries meaning:
  // framing check on, or mode 1 where it is the ninth bit
  wire late       = fcheck_eff || !nine_bit;
  wire decide     = late ? stop_smp : last_smp;
  // ninth bit: received bit 8, or the stop bit in mode 1
  wire ninth      = nine_bit ? (last_smp ? rxd_i : shift_r[8]) : rxd_i;
  // address frame test under multidrop, match else no delivery
  wire addr_ok    = ninth && addr_match;
  wire accept     = decide && !receive_done_flag_r && (!mdrop_eff || addr_ok);
  wire dropped    = decide && mdrop_eff && !addr_ok;
  wire ferr_set   = stop_smp && fcheck_eff && !rxd_i;

  // address compare needs only shift_r[7:0] and the ninth bit comes from rxd_i,
  // so in early delivery the low byte is already complete at last_smp
  // receiver sequencer
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_r    <= ST_IDLE;
      tick_cnt_r <= 4'h0;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 9'h000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // no reception in mode 0, its shift mode is not built
          tick_cnt_r <= 4'h0;
          bit_cnt_r  <= 4'h0;
          if (rx_enable_r && async_mode && !rxd_i) begin
            state_r <= ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            tick_cnt_r <= tick_cnt_r + 4'h1;
          end
          // a glitch shorter than half a bit is not a start bit
          if (start_mid) begin
            tick_cnt_r <= 4'h0;
            state_r    <= rxd_i ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (tick) begin
            tick_cnt_r <= tick_cnt_r + 4'h1;
          end
          if (data_smp) begin
            shift_r[bit_cnt_r] <= rxd_i;
            bit_cnt_r          <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == last_bit) begin
              state_r <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (tick) begin
            tick_cnt_r <= tick_cnt_r + 4'h1;
          end
          // back to idle at the stop centre to catch a quick next start
          if (stop_smp) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // high bit of the frame is only valid after the last sample lands
  wire [7:0] rx_byte = shift_r[7:0];

  // a software write to the flags is a plain store, so it can set
  // them too; this gives a test path to the flags without a frame
  // serial control register; hardware sets win over software writes
  always @(posedge clk_i) begin
    if (srst_i) begin
      // whole control byte from one reset image
      {mode_select_bit0_r, mode_select_bit1_r, multidrop_enable_r, rx_enable_r,
       tx_ninth_bit_r, rx_ninth_bit_r, transmit_done_flag_r,
       receive_done_flag_r} <= `UFCAM_RST_SERCTL;
      frame_error_flag_r   <= 1'b0;
      rx_data_r            <= 8'h00;
    end else begin
      if (wr_serctl) begin
        // bit 7 reaches the error flag or mode bit 0
        if (frame_check_enable_r) begin
          frame_error_flag_r <= pwdata_i[`UFCAM_SC_FERR_MODE0];
        end else begin
          mode_select_bit0_r <= pwdata_i[`UFCAM_SC_FERR_MODE0];
        end
        mode_select_bit1_r   <= pwdata_i[`UFCAM_SC_MODE1];
        multidrop_enable_r   <= pwdata_i[`UFCAM_SC_MDROP];
        rx_enable_r          <= pwdata_i[`UFCAM_SC_REN];
        tx_ninth_bit_r       <= pwdata_i[`UFCAM_SC_TX9];
        rx_ninth_bit_r       <= pwdata_i[`UFCAM_SC_RX9];
        transmit_done_flag_r <= pwdata_i[`UFCAM_SC_TXDONE];
        receive_done_flag_r  <= pwdata_i[`UFCAM_SC_RXDONE];
      end
      // later good frames never clear it; only write or reset
      if (ferr_set) begin
        frame_error_flag_r <= 1'b1;
      end
      if (accept) begin
        receive_done_flag_r <= 1'b1;
        rx_ninth_bit_r      <= ninth;
        rx_data_r           <= rx_byte;
      end
    end
  end

  // power control, address, mask, baud and interrupt mask registers
  always @(posedge clk_i) begin
    if (srst_i) begin
      frame_check_enable_r <= 1'b0;
      own_address_r        <= `UFCAM_RST_ADDR;
      address_mask_r       <= `UFCAM_RST_MASK;
      baud_div_r           <= `UFCAM_RST_BAUD;
      imask_r              <= 3'h0;
    end else if (wr_en) begin
      case (paddr_i)
        `UFCAM_OFS_PWRCTL: frame_check_enable_r <= pwdata_i[`UFCAM_PC_FCE];
        `UFCAM_OFS_ADDR:   own_address_r        <= pwdata_i[7:0];
        // all ones here leaves only the exact own address and the all-ones broadcast
        `UFCAM_OFS_MASK:   address_mask_r       <= pwdata_i[7:0];
        `UFCAM_OFS_BAUD:   baud_div_r           <= pwdata_i[DIV_W-1:0];
        `UFCAM_OFS_IMASK:  imask_r              <= pwdata_i[2:0];
        default: begin
          // other offsets hold nothing here
        end
      endcase
    end
  end

  // interrupt status events, one-cycle pulses from the receiver
  wire [2:0] events;
  assign events[`UFCAM_IS_RXDONE] = accept;
  assign events[`UFCAM_IS_FERR]   = ferr_set;
  assign events[`UFCAM_IS_DROP]   = dropped;

  // read clears only bits the reader saw, so a late event survives
  always @(posedge clk_i) begin
    if (srst_i) begin
      istat_r      <= 3'h0;
      istat_seen_r <= 3'h0;
    end else begin
      if (setup_ph) begin
        istat_seen_r <= istat_r;
      end
      istat_r <= events | (rd_istat ? (istat_r & ~istat_seen_r) : istat_r);
    end
  end

  // only delivery and framing error drive the interrupt line; a
  // dropped frame is logged in the status word but belongs to
  // another station and must not disturb software
  assign irq_o = |(istat_r & imask_r & `UFCAM_IRQ_SRC);

  // register image of the serial control byte
  wire [7:0] serctl_img = {
    frame_check_enable_r ? frame_error_flag_r : mode_select_bit0_r,
    mode_select_bit1_r,
    multidrop_enable_r,
    rx_enable_r,
    tx_ninth_bit_r,
    rx_ninth_bit_r,
    transmit_done_flag_r,
    receive_done_flag_r
  };

  // read mux, also flags unmapped offsets
  reg [31:0] rd_mux;
  always @* begin
    rd_mux   = 32'h00000000;
    addr_hit = 1'b1;
    case (paddr_i)
      `UFCAM_OFS_SERCTL: rd_mux[7:0] = serctl_img;
      `UFCAM_OFS_PWRCTL: rd_mux[0]   = frame_check_enable_r;
      `UFCAM_OFS_ADDR:   rd_mux[7:0] = own_address_r;
      `UFCAM_OFS_MASK:   rd_mux[7:0] = address_mask_r;
      `UFCAM_OFS_RXDATA: rd_mux[7:0] = rx_data_r;
      `UFCAM_OFS_ISTAT:  rd_mux[2:0] = istat_r;
      `UFCAM_OFS_IMASK:  rd_mux[2:0] = imask_r;
      `UFCAM_OFS_BAUD:   rd_mux[DIV_W-1:0] = baud_div_r;
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // read data captured in setup so prdata comes from a flip-flop
  always @(posedge clk_i) begin
    if (srst_i) begin
      prdata_r <= 32'h00000000;
    end else if (setup_ph && !pwrite_i) begin
      prdata_r <= rd_mux;
    end
  end

  // zero wait states; error answer for unmapped offsets
  assign pready_o       = access_ph;
  assign pslverr_o      = access_ph && !addr_hit;
  assign prdata_o       = prdata_r;
  assign tx_ninth_bit_o = tx_ninth_bit_r;

endmodule

/* File: verification/uart_frame_check_address_match_tb.sv */
`timescale 1ns/1ns
`include "ufcam_consts.vh"
// apb master notes expected reads, a watcher compares the answers
module uart_frame_check_address_match_tb;
  localparam logic [33:0] ALL = {34{1'b1}};      // compare every bit
  logic        clk_i     = 1'b0;                 // 10 mhz system clock
  logic        srst_i    = 1'b1;                 // held two cycles
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0;
  wire         pready_o, pslverr_o, tx_ninth_bit_o, irq_o, rxd;
  wire  [31:0] prdata_o;
  logic [33:0] exp_q[$], msk_q[$];               // {irq, error, data} and care mask
  string       nam_q[$];                         // what each read checks
  int          fail_count = 0;
  int          tests_run  = 0;
  int          seed       = 32'h2c3e;
  logic [47:0] tab = 48'h0000_F1FA_56FF;         // own address, mask pairs
  logic [7:0]  own, msk, adr;
  logic        h;                                // expected address match
  int          i, j;
  // clock
  initial forever #50 clk_i = ~clk_i;
  ufcam_top DUT (
    .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .prdata_o(prdata_o), .rxd_i(rxd),
    .tx_ninth_bit_o(tx_ninth_bit_o), .irq_o(irq_o)
  );
  ufcam_serial_src SRC (.clk_i(clk_i), .rxd_o(rxd));
  // one apb transfer, held until pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // note the expectation, then read
  task rd(input string n, input logic [7:0] a, input logic [33:0] e, m);
    nam_q.push_back(n);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  task chk(input string n, input logic [33:0] e, m, s);
    tests_run++;
    if ((s & m) !== (e & m)) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e & m, s & m);
    end
  endtask
  // bench's own address model, independent of the design
  function automatic logic hit(input logic [7:0] a, o, m);
    hit = (((a ^ o) & m) == 8'h00) || (((a ^ (o | m)) & (o | m)) == 8'h00);
  endfunction
  // read answers in access phase against the oldest note
  always @(posedge clk_i) begin
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1 && exp_q.size() > 0) begin
      chk(nam_q.pop_front(), exp_q.pop_front(), msk_q.pop_front(),
          {irq_o, pslverr_o, prdata_o});
    end
  end
  task results;
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // hang guard, well past the longest expected run
  initial begin
    #2000000;
    fail_count++;
    results;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    rd("serctl", `UFCAM_OFS_SERCTL, 34'h0, ALL);
    rd("own", `UFCAM_OFS_ADDR, 34'h0, ALL);
    rd("mask", `UFCAM_OFS_MASK, 34'h0, ALL);
    rd("unmapped", 8'hC0, 34'h1_0000_0000, ALL);
    wr(`UFCAM_OFS_BAUD, 32'h0);
    wr(`UFCAM_OFS_IMASK, 32'h7);
    // mode 1 plain frame, ninth-bit output set
    adr = $random(seed);
    wr(`UFCAM_OFS_SERCTL, 32'h58);
    SRC.send({1'b0, adr}, 8, 1'b1);
    rd("rxdata", `UFCAM_OFS_RXDATA, {26'h200_0000, adr}, ALL);
    rd("istat", `UFCAM_OFS_ISTAT, {2'b10, 32'h1}, ALL);
    rd("serctl", `UFCAM_OFS_SERCTL, 34'h5D, ALL);
    // bad stop sets the error, a good one leaves it
    wr(`UFCAM_OFS_PWRCTL, 32'h1);
    wr(`UFCAM_OFS_SERCTL, 32'h50);
    SRC.send({1'b0, adr}, 8, 1'b0);
    rd("istat", `UFCAM_OFS_ISTAT, {2'b10, 32'h3}, ALL);
    wr(`UFCAM_OFS_SERCTL, 32'hD0);
    SRC.send({1'b0, ~adr}, 8, 1'b1);
    rd("serctl", `UFCAM_OFS_SERCTL, {2'b10, 32'hD5}, ALL);
    rd("istat", `UFCAM_OFS_ISTAT, {2'b10, 32'h1}, ALL);
    wr(`UFCAM_OFS_SERCTL, 32'h50);
    rd("serctl", `UFCAM_OFS_SERCTL, 34'h50, ALL);
    wr(`UFCAM_OFS_PWRCTL, 32'h0);
    // mode 3 multidrop: address frames filtered by given and broadcast match
    for (i = 0; i < 3; i++) begin
      own = tab[47-16*i -: 8];
      msk = tab[39-16*i -: 8];
      wr(`UFCAM_OFS_ADDR, {24'h0, own});
      wr(`UFCAM_OFS_MASK, {24'h0, msk});
      for (j = 0; j < 4; j++) begin
        adr = (j == 0) ? own : (j == 1) ? $random(seed) : (j == 2) ? (own | msk) : own ^ 8'h01;
        wr(`UFCAM_OFS_SERCTL, 32'hF0);
        SRC.send({1'b1, adr}, 9, 1'b1);
        h = hit(adr, own, msk);
        // a foreign frame is only logged, the interrupt follows delivery alone
        rd("addr hit", `UFCAM_OFS_ISTAT, {h, 32'h0, h}, 34'h2_0000_0001);
      end
    end
    wr(`UFCAM_OFS_SERCTL, 32'hF0);
    SRC.send({1'b0, own}, 9, 1'b1);
    rd("data frame", `UFCAM_OFS_ISTAT, 34'h0, 34'h2_0000_0001);
    // mode 1 multidrop: stop bit stands for the ninth bit
    wr(`UFCAM_OFS_SERCTL, 32'h70);
    SRC.send({1'b0, own}, 8, 1'b1);
    rd("m1 stop 1", `UFCAM_OFS_ISTAT, 34'h1, 34'h1);
    wr(`UFCAM_OFS_SERCTL, 32'h70);
    SRC.send({1'b0, own}, 8, 1'b0);
    rd("m1 stop 0", `UFCAM_OFS_ISTAT, 34'h0, 34'h2_0000_0001);
    // no multidrop: foreign address still delivered
    wr(`UFCAM_OFS_SERCTL, 32'hD0);
    SRC.send({1'b0, 8'h00}, 9, 1'b1);
    rd("no filter", `UFCAM_OFS_ISTAT, 34'h1, 34'h1);
    // mode 0: line ignored despite check and multidrop
    wr(`UFCAM_OFS_SERCTL, 32'h30);
    wr(`UFCAM_OFS_PWRCTL, 32'h1);
    SRC.send({1'b0, own}, 8, 1'b0);
    rd("mode 0", `UFCAM_OFS_ISTAT, 34'h0, 34'h3);
    // masking a pending event drops the interrupt
    wr(`UFCAM_OFS_PWRCTL, 32'h0);
    wr(`UFCAM_OFS_SERCTL, 32'h50);
    SRC.send({1'b0, adr}, 8, 1'b1);
    wr(`UFCAM_OFS_IMASK, 32'h0);
    rd("masked", `UFCAM_OFS_ISTAT, 34'h1, ALL);
    results;
  end
endmodule

/* File: verification/ufcam_monitor.sv */
`timescale 1ns/1ns
`include "ufcam_consts.vh"
// watches apb answers, ninth-bit output and interrupt at the top ports
module ufcam_monitor (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        srst_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [31:0] prdata_o,
  // serial side and interrupt
  input wire logic        tx_ninth_bit_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // access phase of any transfer
  sequence s_acc;
    psel_i && penable_i;
  endsequence
  // write access to one register
  sequence s_wr(a);
    psel_i && penable_i && pwrite_i && paddr_i == a;
  endsequence
  property p_rdy;
    s_acc |-> pready_o;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready low in access phase");
  property p_idle;
    !(psel_i && penable_i) |-> !pready_o && !pslverr_o;
  endproperty
  a_idle: assert property (p_idle) else $error("answer outside access phase");
  property p_map;
    s_acc ##0 (paddr_i == `UFCAM_OFS_SERCTL) |->
      !pslverr_o && (pwrite_i || prdata_o[31:8] == 24'h0);
  endproperty
  a_map: assert property (p_map) else $error("serial control access refused");
  property p_bad;
    s_acc ##0 (pslverr_o && !pwrite_i) |-> prdata_o == 32'h0;
  endproperty
  a_bad: assert property (p_bad) else $error("refused read returned data");
  property p_tb8;
    s_wr(`UFCAM_OFS_SERCTL) |=> tx_ninth_bit_o == $past(pwdata_i[`UFCAM_SC_TX9]);
  endproperty
  a_tb8: assert property (p_tb8) else $error("ninth bit output not from write");
  property p_rst;
    $fell(srst_i) |-> !irq_o && !tx_ninth_bit_o && prdata_o == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_stick;
    irq_o && !psel_i |=> irq_o;
  endproperty
  a_stick: assert property (p_stick) else $error("event dropped without software");
  property p_mask;
    s_wr(`UFCAM_OFS_IMASK) ##0 (pwdata_i == 32'h0) |=> !irq_o;
  endproperty
  a_mask: assert property (p_mask) else $error("interrupt high with all masked");
endmodule

bind ufcam_top ufcam_monitor MON (
  .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .prdata_o(prdata_o), .tx_ninth_bit_o(tx_ninth_bit_o),
  .irq_o(irq_o)
);

/* File: verification/ufcam_serial_src.sv */
`timescale 1ns/1ns
// remote transmitter: one frame per call, 16 clocks per bit
module ufcam_serial_src (
  // clock
  input  wire logic clk_i,
  // serial line
  output logic      rxd_o
);
  // line idles high between frames
  initial rxd_o = 1'b1;
  // start, data lsb first, optional ninth, then stop of chosen level
  task automatic send(input logic [8:0] d, input int nb, input logic stp);
    int i;
    for (i = -1; i <= nb; i++) begin
      @(posedge clk_i);
      rxd_o <= (i < 0) ? 1'b0 : (i == nb) ? stp : d[i];
      repeat (15) @(posedge clk_i);
    end
    @(posedge clk_i);
    rxd_o <= 1'b1;
    // idle gap so delivery lands before the next read
    repeat (20) @(posedge clk_i);
  endtask
endmodule
